// ===== pkg/mia_pkg.sv
package mia_pkg;

   // register offsets on the management bus
   localparam logic [4:0] OFS_CTRL = 5'h0d;
   localparam logic [4:0] OFS_DATA = 5'h0e;

   // control register fields
   localparam int CTRL_MODE_MSB = 15;
   localparam int CTRL_MODE_LSB = 14;
   localparam int CTRL_DEV_MSB = 4;
   localparam int CTRL_DEV_LSB = 0;

   // reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] DATA_RESET = 16'h0000;

   // portal operation modes
   typedef enum logic [1:0] {
      MODE_ADDR = 2'h0,
      MODE_DATA = 2'h1,
      MODE_INC_RW = 2'h2,
      MODE_INC_W = 2'h3
   } mia_mode_t;

   // management frame opcodes
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;

   // frame bit counts, in link clock periods
   localparam logic [5:0] PRE_MIN = 6'h20;
   localparam logic [5:0] HDR_LAST = 6'h0c;
   localparam logic [5:0] TA_LAST = 6'h01;
   localparam logic [5:0] DATA_LAST = 6'h0f;

   // serial engine states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_HDR = 4'h2,
      ST_TURN = 4'h4,
      ST_DATA = 4'h8
   } mia_state_t;

endpackage : mia_pkg

// ===== verilog/mia_sync.sv
`timescale 1ns/100ps
module mia_sync
   import mia_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdc_s,
   output logic mdio_s
);

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
   } mia_sync_t;

   mia_sync_t sync_reg;
   mia_sync_t sync_next;

   // first stage only feeds the second stage
   always_comb begin
      sync_next.s1 = {mdc, mdio_i};
      sync_next.s2 = sync_reg.s1;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign mdc_s = sync_reg.s2[1];
   assign mdio_s = sync_reg.s2[0];

endmodule : mia_sync

// ===== verilog/mia_portal.sv
`timescale 1ns/100ps
module mia_portal
   import mia_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h01
)
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   output logic [4:0] mmd_dev,
   output logic [15:0] mmd_addr,
   output logic mmd_rd,
   input wire logic [15:0] mmd_rdata,
   output logic mmd_wr,
   output logic [15:0] mmd_wdata
);

   typedef struct packed {
      mia_state_t st;
      logic [5:0] cnt;
      logic [15:0] shift;
      logic rd;
      logic hit;
      logic to_data;
      logic [15:0] ctrl;
      logic [15:0] addr;
      logic mmd_rd;
      logic mmd_wr;
      logic [15:0] wdata;
      logic inc_pend;
      logic mdc_d;
      logic mdio_o;
      logic mdio_oe;
   } mia_regs_t;

   mia_regs_t r_reg;
   mia_regs_t r_next;
   logic mdc_s;
   logic mdio_s;
   logic rise;
   logic [15:0] word;
   logic [12:0] hdr;
   logic [1:0] mode;
   logic ev_wr_e;
   logic ev_rd_e;
   logic ev_wr_d;

   // data modes are every mode except address load
   function automatic logic is_data_mode(input logic [1:0] m);
      return m != MODE_ADDR;
   endfunction : is_data_mode

   // whether the stored address advances after this transfer
   function automatic logic post_inc(input logic [1:0] m, input logic is_write);
      return (m == MODE_INC_RW) || (is_write && (m == MODE_INC_W));
   endfunction : post_inc

   // link pins cross into the mclk domain
   mia_sync u_sync (
      .mclk(mclk),
      .srst(srst),
      .mdc(mdc),
      .mdio_i(mdio_i),
      .mdc_s(mdc_s),
      .mdio_s(mdio_s)
   );

   assign rise = mdc_s & ~r_reg.mdc_d;
   assign word = {r_reg.shift[14:0], mdio_s};
   assign hdr = {r_reg.shift[11:0], mdio_s};
   assign mode = r_reg.ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB];

   // frame engine, one step per rising link clock edge
   always_comb begin
      r_next = r_reg;
      r_next.mmd_rd = 1'b0;
      r_next.mmd_wr = 1'b0;
      r_next.mdc_d = mdc_s;
      ev_wr_e = 1'b0;
      ev_rd_e = 1'b0;
      ev_wr_d = 1'b0;
      r_next.inc_pend = 1'b0;
      // write increment waits one cycle so the strobe sees the address it used
      if (r_reg.inc_pend) begin
         r_next.addr = r_reg.addr + 16'h0001;
      end
      // indirect read data is valid while the strobe is high
      if (r_reg.mmd_rd) begin
         r_next.shift = mmd_rdata;
      end
      if (rise) begin
         case (r_reg.st)
            ST_IDLE: begin
               if (mdio_s) begin
                  if (r_reg.cnt < PRE_MIN) begin
                     r_next.cnt = r_reg.cnt + 6'h01;
                  end
               end else if (r_reg.cnt == PRE_MIN) begin
                  r_next.st = ST_HDR;
                  r_next.cnt = '0;
                  r_next.shift = '0;
               end else begin
                  r_next.cnt = '0;
               end
            end
            ST_HDR: begin
               r_next.shift = word;
               r_next.cnt = r_reg.cnt + 6'h01;
               if (r_reg.cnt == HDR_LAST) begin
                  r_next.st = ST_TURN;
                  r_next.cnt = '0;
                  r_next.rd = hdr[11:10] == OP_READ;
                  r_next.to_data = hdr[4:0] == OFS_DATA;
                  // only the two portal registers answer
                  r_next.hit = hdr[12] && (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE) &&
                     hdr[9:5] == PHY_ADDR && (hdr[4:0] == OFS_CTRL || hdr[4:0] == OFS_DATA);
                  if (hdr[4:0] == OFS_DATA) begin
                     r_next.shift = r_reg.addr;
                  end else begin
                     r_next.shift = r_reg.ctrl;
                  end
                  // fetch early; turnaround leaves many mclk cycles
                  if (r_next.hit && r_next.rd && r_next.to_data && is_data_mode(mode)) begin
                     r_next.mmd_rd = 1'b1;
                  end
               end
            end
            ST_TURN: begin
               r_next.cnt = r_reg.cnt + 6'h01;
               if (r_reg.rd && r_reg.hit) begin
                  r_next.mdio_oe = 1'b1;
                  r_next.mdio_o = 1'b0;
               end
               if (r_reg.cnt == TA_LAST) begin
                  r_next.st = ST_DATA;
                  r_next.cnt = '0;
                  if (r_reg.rd && r_reg.hit) begin
                     r_next.mdio_o = r_reg.shift[15];
                     r_next.shift = {r_reg.shift[14:0], 1'b0};
                  end
               end
            end
            ST_DATA: begin
               r_next.cnt = r_reg.cnt + 6'h01;
               if (r_reg.rd) begin
                  r_next.mdio_o = r_reg.hit & r_reg.shift[15];
                  r_next.shift = {r_reg.shift[14:0], 1'b0};
               end else begin
                  r_next.shift = word;
               end
               if (r_reg.cnt == DATA_LAST) begin
                  r_next.st = ST_IDLE;
                  r_next.cnt = '0;
                  r_next.mdio_oe = 1'b0;
                  r_next.mdio_o = 1'b0;
                  if (r_reg.hit && r_reg.rd && r_reg.to_data) begin
                     ev_rd_e = 1'b1;
                     // block reads walk forward one register
                     if (post_inc(mode, 1'b0)) begin
                        r_next.addr = r_reg.addr + 16'h0001;
                     end
                  end
                  if (r_reg.hit && !r_reg.rd && !r_reg.to_data) begin
                     ev_wr_d = 1'b1;
                     r_next.ctrl = word;
                  end
                  if (r_reg.hit && !r_reg.rd && r_reg.to_data) begin
                     ev_wr_e = 1'b1;
                     if (!is_data_mode(mode)) begin
                        r_next.addr = word;
                     end else begin
                        r_next.mmd_wr = 1'b1;
                        r_next.wdata = word;
                        if (post_inc(mode, 1'b1)) begin
                           r_next.inc_pend = 1'b1;
                        end
                     end
                  end
               end
            end
            default: begin
               r_next.st = ST_IDLE;
               r_next.cnt = '0;
            end
         endcase
      end
   end

   // synchronous reset clears mode, device, reserved bits and address
   always_ff @(posedge mclk) begin
      if (srst) begin
         r_reg <= '0;
         r_reg.st <= ST_IDLE;
         r_reg.ctrl <= CTRL_RESET;
         r_reg.addr <= DATA_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   // indirect space: 5-bit device, 16-bit address, 16-bit data
   assign mmd_dev = r_reg.ctrl[CTRL_DEV_MSB:CTRL_DEV_LSB];
   assign mmd_addr = r_reg.addr;
   assign mmd_rd = r_reg.mmd_rd;
   assign mmd_wr = r_reg.mmd_wr;
   assign mmd_wdata = r_reg.wdata;
   assign mdio_o = r_reg.mdio_o;
   assign mdio_oe = r_reg.mdio_oe;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   a_addr_load: assert property (ev_wr_e && mode == MODE_ADDR |=> r_reg.addr == $past(word))
      else $error("address load lost");
   a_addr_hold: assert property ((ev_wr_e || ev_rd_e) && mode == MODE_DATA |=> $stable(r_reg.addr))
      else $error("address moved in mode 01");
   a_inc_rw: assert property (ev_rd_e && mode == MODE_INC_RW
      |=> r_reg.addr == $past(r_reg.addr) + 16'h0001)
      else $error("no increment in mode 10");
   a_inc_rw_wr: assert property (ev_wr_e && mode == MODE_INC_RW
      |=> ##1 r_reg.addr == $past(r_reg.addr, 2) + 16'h0001)
      else $error("write did not increment in mode 10");
   a_inc_wr_only: assert property (ev_rd_e && mode == MODE_INC_W |=> $stable(r_reg.addr))
      else $error("read incremented in mode 11");
   a_inc_wr_step: assert property (ev_wr_e && mode == MODE_INC_W
      |=> ##1 r_reg.addr == $past(r_reg.addr, 2) + 16'h0001)
      else $error("write did not increment in mode 11");
   a_data_write: assert property (ev_wr_e && mode != MODE_ADDR
      |=> mmd_wr && mmd_wdata == $past(word) && mmd_addr == $past(r_reg.addr))
      else $error("indirect write wrong");
   a_ctrl_load: assert property (ev_wr_d |=> mmd_dev == $past(word[4:0]) && r_reg.ctrl == $past(word))
      else $error("control load wrong");
   a_reset_zero: assert property ($past(srst) |-> r_reg.ctrl == 16'h0000 && mmd_addr == 16'h0000)
      else $error("not cleared by reset");
   a_ta_low: assert property ($rose(mdio_oe) |-> !mdio_o ##1 mdio_oe [*3])
      else $error("turnaround not driven low");
   a_rd_fetch: assert property (mmd_rd |-> mode != MODE_ADDR && r_reg.st == ST_TURN && !mdio_oe)
      else $error("fetch outside data mode");

endmodule : mia_portal

// ===== verif/mia_ctrl_model.sv
`timescale 1ns/100ps
module mia_ctrl_model
   import mia_pkg::*;
(
   input wire logic mclk,
   input wire logic mdio_line,
   output logic mdc,
   output logic mdio_drv,
   output logic mdio_en
);
   // link clock rests low and the line is released between frames
   initial begin
      mdc = 1'b0;
      mdio_drv = 1'b1;
      mdio_en = 1'b0;
   end

   // one link period: data changes while mdc is low, sampled as mdc rises
   task automatic bit_cycle(input logic d, input logic en, output logic s);
      mdio_drv = d;
      mdio_en = en;
      repeat (4) @(negedge mclk);
      mdc = 1'b1;
      s = mdio_line;
      repeat (4) @(negedge mclk);
      mdc = 1'b0;
   endtask : bit_cycle

   // full frame with its own preamble; both turnaround bits released on reads
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [31:0] word;
      logic s;
      logic is_rd;
      word = {2'b01, op, pa, ra, 2'b10, wd};
      is_rd = (op == OP_READ);
      for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
      for (int i = 31; i >= 0; i--) begin
         bit_cycle(word[i], !(is_rd && i < 18), s);
         rd = {rd[14:0], s}; // last sixteen samples are the data
      end
      mdio_en = 1'b0;
   endtask : frame
endmodule : mia_ctrl_model

// ===== verif/mia_portal_bench.sv
`timescale 1ns/100ps
module mia_portal_bench
   import mia_pkg::*;
;
   typedef struct packed {logic wr; logic [4:0] ra; logic [15:0] val; logic [15:0] addr;} mia_row_t;
   localparam logic [4:0] PHY_A = 5'h03;
   logic mclk, srst, mdc, mdio_drv, mdio_en, mdio_o, mdio_oe, mdio_line, mmd_rd, mmd_wr;
   logic [4:0] mmd_dev;
   logic [15:0] mmd_addr, mmd_rdata, mmd_wdata, rd;
   logic [31:0] last_wr;
   int n_errors, compares;
   int n_fetch;
   // write/read, register, write value or expected read, stored address after
   mia_row_t rows [23] = '{
      '{1'b1, OFS_CTRL, 16'h0002, 16'h0000},
      '{1'b1, OFS_DATA, 16'h0010, 16'h0010},
      '{1'b0, OFS_DATA, 16'h0010, 16'h0010},
      '{1'b0, OFS_CTRL, 16'h0002, 16'h0010},
      '{1'b1, OFS_CTRL, 16'h4002, 16'h0010},
      '{1'b1, OFS_DATA, 16'h0001, 16'h0010},
      '{1'b0, OFS_DATA, 16'hffed, 16'h0010},
      '{1'b1, OFS_CTRL, 16'h0002, 16'h0010},
      '{1'b1, OFS_DATA, 16'h0011, 16'h0011},
      '{1'b1, OFS_CTRL, 16'h8002, 16'h0011},
      '{1'b0, OFS_DATA, 16'hffec, 16'h0012},
      '{1'b0, OFS_DATA, 16'hffef, 16'h0013},
      '{1'b1, OFS_DATA, 16'h1234, 16'h0014},
      '{1'b1, OFS_CTRL, 16'hc01f, 16'h0014},
      '{1'b0, OFS_DATA, 16'hfff4, 16'h0014},
      '{1'b1, OFS_DATA, 16'habcd, 16'h0015},
      '{1'b0, OFS_CTRL, 16'hc01f, 16'h0015},
      '{1'b1, OFS_CTRL, 16'h3fe0, 16'h0015},
      '{1'b0, OFS_CTRL, 16'h3fe0, 16'h0015},
      '{1'b0, OFS_DATA, 16'h0015, 16'h0015},
      '{1'b1, OFS_DATA, 16'hffff, 16'hffff},
      '{1'b1, OFS_CTRL, 16'h8000, 16'hffff},
      '{1'b0, OFS_DATA, 16'h0000, 16'h0000}
   };

   // pull-up on the shared data line; indirect space content follows location
   assign mdio_line = mdio_oe ? mdio_o : (mdio_en ? mdio_drv : 1'b1);
   assign mmd_rdata = ~mmd_addr ^ {11'h000, mmd_dev};

   mia_portal #(.PHY_ADDR(PHY_A)) i_dut (.mclk(mclk), .srst(srst), .mdc(mdc), .mdio_i(mdio_line),
      .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mmd_dev(mmd_dev), .mmd_addr(mmd_addr), .mmd_rd(mmd_rd),
      .mmd_rdata(mmd_rdata), .mmd_wr(mmd_wr), .mmd_wdata(mmd_wdata));
   mia_ctrl_model i_ctrl (.mclk(mclk), .mdio_line(mdio_line), .mdc(mdc), .mdio_drv(mdio_drv),
      .mdio_en(mdio_en));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // remember where the last indirect write went
   always @(posedge mclk) begin
      if (mmd_wr === 1'b1) last_wr <= {mmd_addr, mmd_wdata};
   end

   // one indirect fetch per data-mode read of the address/data register
   always @(posedge mclk) begin
      if (mmd_rd === 1'b1) n_fetch <= n_fetch + 1;
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // settle time covers sync, write pulse and post-increment
   task automatic access(input logic wr, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
      i_ctrl.frame(wr ? OP_WRITE : OP_READ, pa, ra, wd, rd);
      repeat (8) @(negedge mclk);
   endtask : access

   task automatic do_reset;
      srst = 1'b1;
      repeat (8) @(negedge mclk);
      srst = 1'b0;
      repeat (4) @(negedge mclk);
   endtask : do_reset

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict

   // about 35 frames of 10 us each; nearly three times that is a hang
   initial begin
      #1ms;
      n_errors++;
      print_verdict();
   end

   initial begin
      n_errors = 0;
      compares = 0;
      do_reset();
      check("addr rst", 16'h0000, mmd_addr);
      access(1'b0, PHY_A, OFS_CTRL, 16'h0000);
      check("ctrl rst", 16'h0000, rd);
      $display("reset test done");
      for (int i = 0; i < $size(rows); i++) begin
         access(rows[i].wr, PHY_A, rows[i].ra, rows[i].val);
         if (rows[i].wr === 1'b0) check("read", rows[i].val, rd);
         check("mmd_addr", rows[i].addr, mmd_addr);
      end
      check("fetches", 16'h0005, n_fetch[15:0]);
      $display("row test done");
      // data write lands at the stored address of the selected device
      access(1'b1, PHY_A, OFS_CTRL, 16'h4005);
      access(1'b1, PHY_A, OFS_DATA, 16'h5a5a);
      check("wr addr", 16'h0000, last_wr[31:16]);
      check("wr data", 16'h5a5a, last_wr[15:0]);
      check("dev", 16'h0005, {11'h000, mmd_dev});
      // foreign address and unmapped register leave the line and state alone
      access(1'b1, 5'h04, OFS_CTRL, 16'h0003);
      access(1'b0, 5'h04, OFS_CTRL, 16'h0000);
      check("foreign", 16'hffff, rd);
      access(1'b0, PHY_A, 5'h0c, 16'h0000);
      check("unmapped", 16'hffff, rd);
      access(1'b0, PHY_A, OFS_CTRL, 16'h0000);
      check("ctrl kept", 16'h4005, rd);
      // incrementing write still lands at the address it was aimed at
      access(1'b1, PHY_A, OFS_CTRL, 16'hc005);
      access(1'b1, PHY_A, OFS_DATA, 16'h7777);
      check("inc wr addr", 16'h0000, last_wr[31:16]);
      check("inc addr", 16'h0001, mmd_addr);
      $display("refusal test done");
      do_reset();
      access(1'b0, PHY_A, OFS_CTRL, 16'h0000);
      check("ctrl rerst", 16'h0000, rd);
      access(1'b0, PHY_A, OFS_DATA, 16'h0000);
      check("data rerst", 16'h0000, rd);
      $display("second reset test done");
      print_verdict();
   end
endmodule : mia_portal_bench
